// File: logic/dcr_pkg.sv
// Purpose: Shared constants and types for device control and relink
// Assumes: 7-bit register address, 8-bit register data
// Notes:   Mode register offsets are local choices
package dcr_pkg;

  // ==========================================================
  // Register map
  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 8;
  localparam logic [6:0]  A_LNK_UPD      = 7'h3E;
  localparam logic [6:0]  A_RST_OUT      = 7'h50;
  localparam logic [6:0]  A_TEST_CODE    = 7'h7E;
  localparam logic [6:0]  A_TEST_CH      = 7'h7F;
  localparam logic [6:0]  A_TX_PWR       = 7'h56;
  localparam logic [6:0]  A_RX_PWR       = 7'h49;
  localparam logic [6:0]  A_TX_MODE      = 7'h20;
  localparam logic [6:0]  A_RX_MODE      = 7'h21;
  localparam logic [6:0]  A_LNK_MODE     = 7'h22;

  // ==========================================================
  // Field layout and values
  localparam int          RSTO_POL_BIT   = 0;
  localparam int          RSTO_SEL_LSB   = 1;
  localparam int          RSTO_SEL_MSB   = 3;
  localparam logic [2:0]  RSTO_SEL_ON    = 3'h4;
  localparam logic [3:0]  RSTO_RESET     = 4'h0;
  localparam int          TXMODE_PD_BIT  = 6;
  localparam int          RXMODE_PD_BIT  = 7;
  localparam int          LNKMODE_FORCE  = 4;
  localparam int          TEST_CHANNEL_DIRECTION_DIR_BIT = 7;
  localparam logic [7:0]  LNK_START      = 8'h01;
  localparam logic [7:0]  TEST_SINGLE    = 8'h63;
  localparam logic [7:0]  TEST_SWEEP     = 8'h73;
  localparam logic [1:0]  PWR_0DBM       = 2'h3;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  // ==========================================================
  // Timing
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          PULSE_US       = 285;
  localparam int          PULSE_CYC      = (PULSE_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LS_IDLE_OK   = 2'b00,
    LS_BUSY      = 2'b01,
    LS_IDLE_FAIL = 2'b10
  } dcr_lnk_st_t;

  typedef enum logic [1:0] {
    TK_NONE   = 2'b00,
    TK_SINGLE = 2'b01,
    TK_SWEEP  = 2'b10
  } dcr_test_kind_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dcr_reg_req_t;

  typedef struct packed {
    dcr_test_kind_t kind;
    logic           tx_dir;
    logic [6:0]     channel;
  } dcr_test_cfg_t;

endpackage : dcr_pkg

// File: logic/dcr_pulse_gen.sv
// Purpose: Fixed-length pulse on the peripheral reset pin
// Assumes: start is a one-cycle pulse
// Notes:   Pin idles at the level opposite to the polarity
`timescale 1ns/1ps
`default_nettype none
module dcr_pulse_gen
  import dcr_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  input  wire logic clk,    // System clock
  input  wire logic srst,   // Sync reset
  input  wire logic start,  // Begin one pulse
  input  wire logic enable, // Pulse allowed
  input  wire logic pol,    // 1 active high
  output var  logic pin_q   // Reset output pin
);

  localparam int CW = $clog2(PULSE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          act_q, act_d;
  logic          pin_d;

  // ==========================================================
  // Next state
  always_comb begin
    cnt_d = cnt_q;
    act_d = act_q;
    if (act_q) begin
      if (cnt_q == LAST) begin
        act_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end else if (start && enable) begin
      act_d = 1'b1;
      cnt_d = '0;
    end
    pin_d = act_d ? pol : ~pol;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      act_q <= 1'b0;
      pin_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      act_q <= act_d;
      pin_q <= pin_d;
    end
  end

endmodule : dcr_pulse_gen
`default_nettype wire

// File: logic/dcr_top.sv
// Purpose: Device control: reset pulse, power-down, relink, test mode
// Assumes: Register requests arrive decoded from the serial slave port
// Notes:   Straps are caught on every clock of srst
//
// Behaviour
// - Transmitter pulses reset pin after reconfigure; none after boot, as the select field resets to 0 (off)
// - No reset pulse in receiver role
// - Select field 0 off, 4 on
// - Bit 0 chooses pulse polarity
// - Pulse lasts about 285 us
// - Transmitter sleeps on mode bit 6 write
// - Receiver sleeps on mode bit 7 write
// - Wake on falling chip-select (SPI strap) or data line (two-wire strap), not on the other pin
// - Registers keep contents through power-down
// - Audio pins inputs until link established
// - Writing 1 starts link register transfer, in transmitter role only
// - Reads 1 while busy, 0 on success
// - Failed transfer leaves value 2
// - Relink after link or force bit 4
// - Test registers then force bit enters test
// - Test mode held until reset
// - Codes select single-channel or sweep test
// - Bit 7 direction, bits 6:0 channel
// - Test mode forces 0 dBm output power
// - Test registers reachable over slave port
`timescale 1ns/1ps
`default_nettype none
module dcr_top
  import dcr_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  input  wire logic          clk,               // System clock
  input  wire logic          srst,              // Sync reset, high
  input  wire logic          role_tx_strap,     // 1 transmitter, 0 receiver
  input  wire logic          slave_sel_strap,   // 0 SPI, 1 two-wire
  input  wire dcr_reg_req_t  reg_req,           // Register access
  output var  logic [7:0]    reg_rdata,         // Read data, next cycle
  input  wire logic          spi_csn_pin,       // SPI chip select
  input  wire logic          two_wire_data_pin, // Two-wire data input
  input  wire logic          link_established,  // Link up pulse
  input  wire logic          xfer_done,         // Transfer finished ok
  input  wire logic          xfer_fail,         // Transfer failed
  output var  logic          peripheral_reset_pin, // Reset output pin
  output var  logic          power_down,        // Power-down state
  output var  logic          audio_pins_input,  // Audio pins held as inputs
  output var  logic          xfer_start,        // Start transfer pulse
  output var  logic          reconfig,          // Reconfigure pulse
  output var  logic          test_mode,         // Test mode active
  output var  dcr_test_cfg_t test_cfg,          // Test settings in force
  output var  logic [1:0]    rf_power_sel       // Effective output power
);

  // ==========================================================
  // Straps and boot
  logic role_tx_q, role_tx_d;
  logic ssel_q, ssel_d;
  logic boot_q, boot_d;

  always_comb begin
    role_tx_d = role_tx_q;
    ssel_d    = ssel_q;
    boot_d    = 1'b0;
  end

  // Straps sampled while reset holds, not reset to a constant
  always_ff @(posedge clk) begin
    if (srst) begin
      role_tx_q <= role_tx_strap;
      ssel_q    <= slave_sel_strap;
      boot_q    <= 1'b1;
    end else begin
      role_tx_q <= role_tx_d;
      ssel_q    <= ssel_d;
      boot_q    <= boot_d;
    end
  end

  // ==========================================================
  // Register decode
  logic wr_upd, wr_rst, wr_tcode, wr_tch;
  logic wr_txp, wr_rxp, wr_txm, wr_rxm, wr_lnm;

  always_comb begin
    wr_upd   = reg_req.wr && reg_req.addr == A_LNK_UPD;
    wr_rst   = reg_req.wr && reg_req.addr == A_RST_OUT;
    wr_tcode = reg_req.wr && reg_req.addr == A_TEST_CODE;
    wr_tch   = reg_req.wr && reg_req.addr == A_TEST_CH;
    wr_txp   = reg_req.wr && reg_req.addr == A_TX_PWR;
    wr_rxp   = reg_req.wr && reg_req.addr == A_RX_PWR;
    wr_txm   = reg_req.wr && reg_req.addr == A_TX_MODE;
    wr_rxm   = reg_req.wr && reg_req.addr == A_RX_MODE;
    wr_lnm   = reg_req.wr && reg_req.addr == A_LNK_MODE;
  end

  // ==========================================================
  // Plain storage registers
  logic [3:0] rsto_q, rsto_d;
  logic [7:0] tcode_q, tcode_d;
  logic [7:0] tch_q, tch_d;
  logic [1:0] txp_q, txp_d;
  logic [1:0] rxp_q, rxp_d;
  logic [7:0] txm_q, txm_d;
  logic [7:0] rxm_q, rxm_d;
  logic [7:0] lnm_q, lnm_d;

  always_comb begin
    rsto_d  = rsto_q;
    tcode_d = tcode_q;
    tch_d   = tch_q;
    txp_d   = txp_q;
    rxp_d   = rxp_q;
    txm_d   = txm_q;
    rxm_d   = rxm_q;
    lnm_d   = lnm_q;
    // Reserved upper bits are dropped so they read zero
    if (wr_rst) begin
      rsto_d = reg_req.wdata[RSTO_SEL_MSB:0];
    end
    if (wr_tcode) begin
      tcode_d = reg_req.wdata;
    end
    if (wr_tch) begin
      tch_d = reg_req.wdata;
    end
    if (wr_txp) begin
      txp_d = reg_req.wdata[1:0];
    end
    if (wr_rxp) begin
      rxp_d = reg_req.wdata[1:0];
    end
    if (wr_txm) begin
      txm_d = reg_req.wdata;
    end
    if (wr_rxm) begin
      rxm_d = reg_req.wdata;
    end
    // Force bit is a trigger only, never stored
    if (wr_lnm) begin
      lnm_d                = reg_req.wdata;
      lnm_d[LNKMODE_FORCE] = 1'b0;
    end
  end

  // Power-down does not touch any of these
  always_ff @(posedge clk) begin
    if (srst) begin
      rsto_q  <= RSTO_RESET;
      tcode_q <= REG_RESET;
      tch_q   <= REG_RESET;
      txp_q   <= PWR_0DBM;
      rxp_q   <= PWR_0DBM;
      txm_q   <= REG_RESET;
      rxm_q   <= REG_RESET;
      lnm_q   <= REG_RESET;
    end else begin
      rsto_q  <= rsto_d;
      tcode_q <= tcode_d;
      tch_q   <= tch_d;
      txp_q   <= txp_d;
      rxp_q   <= rxp_d;
      txm_q   <= txm_d;
      rxm_q   <= rxm_d;
      lnm_q   <= lnm_d;
    end
  end

  // ==========================================================
  // Power-down and wake
  logic pd_q, pd_d;
  logic wake_prev_q, wake_prev_d;
  logic wake_pin, wake_fall;

  always_comb begin
    wake_pin    = ssel_q ? two_wire_data_pin : spi_csn_pin;
    wake_prev_d = wake_pin;
    wake_fall   = wake_prev_q && !wake_pin;
    pd_d        = pd_q;
    if (pd_q && wake_fall) begin
      pd_d = 1'b0;
    end else if (role_tx_q && wr_txm && reg_req.wdata[TXMODE_PD_BIT]) begin
      pd_d = 1'b1;
    end else if (!role_tx_q && wr_rxm && reg_req.wdata[RXMODE_PD_BIT]) begin
      pd_d = 1'b1;
    end
  end

  // Previous level reset high so no false edge after boot
  always_ff @(posedge clk) begin
    if (srst) begin
      pd_q        <= 1'b0;
      wake_prev_q <= 1'b1;
    end else begin
      pd_q        <= pd_d;
      wake_prev_q <= wake_prev_d;
    end
  end

  // ==========================================================
  // Link register update engine
  dcr_lnk_st_t lnk_q, lnk_d;
  logic        start_q, start_d;

  always_comb begin
    lnk_d   = lnk_q;
    start_d = 1'b0;
    case (lnk_q)
      LS_IDLE_OK, LS_IDLE_FAIL: begin
        // Receiver side and non-start values are ignored
        if (wr_upd && role_tx_q && reg_req.wdata == LNK_START) begin
          lnk_d   = LS_BUSY;
          start_d = 1'b1;
        end
      end
      LS_BUSY: begin
        // Failure wins if both arrive together
        if (xfer_fail) begin
          lnk_d = LS_IDLE_FAIL;
        end else if (xfer_done) begin
          lnk_d = LS_IDLE_OK;
        end
      end
      default: begin
        lnk_d = LS_IDLE_OK;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lnk_q   <= LS_IDLE_OK;
      start_q <= 1'b0;
    end else begin
      lnk_q   <= lnk_d;
      start_q <= start_d;
    end
  end

  // ==========================================================
  // Reconfiguration and test mode
  logic           force_wr;
  logic           rcfg_q, rcfg_d;
  logic           tm_q, tm_d;
  logic           audio_in_q, audio_in_d;
  dcr_test_kind_t code_kind;
  dcr_test_cfg_t  tcfg_q, tcfg_d;

  always_comb begin
    force_wr = wr_lnm && reg_req.wdata[LNKMODE_FORCE];
    case (tcode_q)
      TEST_SINGLE: code_kind = TK_SINGLE;
      TEST_SWEEP:  code_kind = TK_SWEEP;
      default:     code_kind = TK_NONE;
    endcase
    rcfg_d     = force_wr || link_established;
    tm_d       = tm_q;
    tcfg_d     = tcfg_q;
    audio_in_d = audio_in_q && !link_established;
    // Settings frozen once in test mode; only reset leaves
    if (!tm_q && force_wr && code_kind != TK_NONE) begin
      tm_d           = 1'b1;
      tcfg_d.kind    = code_kind;
      tcfg_d.tx_dir  = tch_q[TEST_CHANNEL_DIRECTION_DIR_BIT];
      tcfg_d.channel = tch_q[TEST_CHANNEL_DIRECTION_DIR_BIT-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rcfg_q     <= 1'b0;
      tm_q       <= 1'b0;
      tcfg_q     <= '0;
      audio_in_q <= 1'b1;
    end else begin
      rcfg_q     <= rcfg_d;
      tm_q       <= tm_d;
      tcfg_q     <= tcfg_d;
      audio_in_q <= audio_in_d;
    end
  end

  // ==========================================================
  // Output power and read data
  logic [1:0] pwr_q, pwr_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    // Follows the next test state so power never lags test entry
    if (tm_d) begin
      pwr_d = PWR_0DBM;
    end else begin
      pwr_d = role_tx_q ? txp_q : rxp_q;
    end
    rdata_d = REG_RESET;
    if (reg_req.rd) begin
      // Test registers are write-only and read zero
      case (reg_req.addr)
        A_LNK_UPD:  rdata_d = {6'h00, lnk_q};
        A_RST_OUT:  rdata_d = {4'h0, rsto_q};
        A_TX_PWR:   rdata_d = {6'h00, txp_q};
        A_RX_PWR:   rdata_d = {6'h00, rxp_q};
        A_TX_MODE:  rdata_d = txm_q;
        A_RX_MODE:  rdata_d = rxm_q;
        A_LNK_MODE: rdata_d = lnm_q;
        default:    rdata_d = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_q   <= PWR_0DBM;
      rdata_q <= REG_RESET;
    end else begin
      pwr_q   <= pwr_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Reset pulse output
  logic pulse_en;
  logic pulse_start;

  always_comb begin
    pulse_en    = role_tx_q && rsto_q[RSTO_SEL_MSB:RSTO_SEL_LSB] == RSTO_SEL_ON;
    pulse_start = boot_q || rcfg_q;
  end

  dcr_pulse_gen #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pulse (
    .clk    (clk),
    .srst   (srst),
    .start  (pulse_start),
    .enable (pulse_en),
    .pol    (rsto_q[RSTO_POL_BIT]),
    .pin_q  (peripheral_reset_pin)
  );

  // ==========================================================
  // Output drive
  always_comb begin
    reg_rdata        = rdata_q;
    power_down       = pd_q;
    audio_pins_input = audio_in_q;
    xfer_start       = start_q;
    reconfig         = rcfg_q;
    test_mode        = tm_q;
    test_cfg         = tcfg_q;
    rf_power_sel     = pwr_q;
  end

endmodule : dcr_top
`default_nettype wire

// File: tb/dcr_checker.sv
// Purpose: Port assertions for dcr_top
// Assumes: Straps change only while srst is high
// Notes:   Bound to dcr_top at the foot
`timescale 1ns/1ps
`default_nettype none
module dcr_checker
  import dcr_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  input wire logic         clk,                  // Clock
  input wire logic         srst,                 // Reset
  input wire logic         role_tx_strap,        // Role
  input wire dcr_reg_req_t reg_req,              // Access
  input wire logic         link_established,     // Link up
  input wire logic         peripheral_reset_pin, // Pin
  input wire logic         power_down,           // Sleep
  input wire logic         audio_pins_input,     // Audio dir
  input wire logic         xfer_start,           // Start
  input wire logic         reconfig,             // Reconfig
  input wire logic         test_mode,            // Test
  input wire logic [1:0]   rf_power_sel          // Power
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_start_cause: assert property (xfer_start |-> $past(role_tx_strap && reg_req.wr &&
    reg_req.addr == A_LNK_UPD && reg_req.wdata == LNK_START)) else $error("stray transfer start");
  a_force_relink: assert property (reg_req.wr && reg_req.addr == A_LNK_MODE &&
    reg_req.wdata[LNKMODE_FORCE] && !test_mode |=> reconfig) else $error("force without reconfig");
  a_link_relink: assert property (link_established |=> reconfig)
    else $error("link without reconfig");
  a_test_hold: assert property (test_mode |=> test_mode) else $error("test mode left");
  a_test_power: assert property (test_mode |-> rf_power_sel == PWR_0DBM)
    else $error("test power not 0 dBm");
  a_tx_sleep: assert property (role_tx_strap && reg_req.wr && reg_req.addr == A_TX_MODE &&
    reg_req.wdata[TXMODE_PD_BIT] |=> power_down) else $error("tx sleep missed");
  a_rx_sleep: assert property (!role_tx_strap && reg_req.wr && reg_req.addr == A_RX_MODE &&
    reg_req.wdata[RXMODE_PD_BIT] |=> power_down) else $error("rx sleep missed");
  a_no_self_sleep: assert property ($rose(power_down) |-> $past(reg_req.wr))
    else $error("sleep without write");
  a_audio_hold: assert property (audio_pins_input && !link_established |=> audio_pins_input)
    else $error("audio pins left input early");
  a_rx_quiet: assert property (!role_tx_strap && !$past(reg_req.wr) |->
    $stable(peripheral_reset_pin)) else $error("pin moved in receiver role");
endmodule : dcr_checker

bind dcr_top dcr_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .clk(clk), .srst(srst), .role_tx_strap(role_tx_strap), .reg_req(reg_req),
  .link_established(link_established), .peripheral_reset_pin(peripheral_reset_pin),
  .power_down(power_down), .audio_pins_input(audio_pins_input), .xfer_start(xfer_start),
  .reconfig(reconfig), .test_mode(test_mode), .rf_power_sel(rf_power_sel));
`default_nettype wire

// File: tb/dcr_chan_model.sv
// Purpose: Far end of the control channel
// Assumes: xfer_start is a one-cycle pulse
// Notes:   Answers after delay cycles, ok or fail
`timescale 1ns/1ps
`default_nettype none
module dcr_chan_model (
  input  wire logic       clk,        // System clock
  input  wire logic       xfer_start, // Transfer request
  input  wire logic       fail_mode,  // Answer with failure
  input  wire logic [7:0] delay,      // Wait before answer
  output var  logic       xfer_done,  // Success pulse
  output var  logic       xfer_fail   // Failure pulse
);
  int cnt = 0;
  initial xfer_done = 1'h0;
  initial xfer_fail = 1'h0;
  // Driven off the sampling edge
  always @(negedge clk) begin
    xfer_done <= 1'h0;
    xfer_fail <= 1'h0;
    if (xfer_start) begin
      cnt <= int'(delay) + 1;
    end else if (cnt == 1) begin
      xfer_done <= !fail_mode;
      xfer_fail <= fail_mode;
      cnt       <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : dcr_chan_model
`default_nettype wire

// File: tb/tb_device_control_and_relink.sv
// Purpose: Self-checking bench for dcr_top
// Assumes: Short pulse length for speed
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_device_control_and_relink;
  import dcr_pkg::*;
  localparam int PC = 20;
  logic          clk, srst, role, ssel, csn, sda, link_up, fmode, done, fail;
  logic          pin, pd, api, xs, rc, tm;
  logic [7:0]    dly, rdata;
  logic [1:0]    pwr;
  dcr_reg_req_t  req;
  dcr_test_cfg_t tcfg;
  int            err_total, n_checks, cnt;

  dcr_top #(.PULSE_CYCLES(PC)) dut (.clk(clk), .srst(srst), .role_tx_strap(role),
    .slave_sel_strap(ssel), .reg_req(req), .reg_rdata(rdata), .spi_csn_pin(csn),
    .two_wire_data_pin(sda), .link_established(link_up), .xfer_done(done), .xfer_fail(fail),
    .peripheral_reset_pin(pin), .power_down(pd), .audio_pins_input(api), .xfer_start(xs),
    .reconfig(rc), .test_mode(tm), .test_cfg(tcfg), .rf_power_sel(pwr));
  dcr_chan_model u_chan (.clk(clk), .xfer_start(xs), .fail_mode(fmode), .delay(dly),
    .xfer_done(done), .xfer_fail(fail));

  always #20 clk = ~clk;

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk);
    req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    chk("rdata", {8'h00, rdata}, {8'h00, exp});
  endtask : rd

  task automatic do_reset(input logic r, input logic s);
    @(negedge clk);
    srst = 1'h1;
    role = r;
    ssel = s;
    repeat (8) @(negedge clk);
    srst = 1'h0;
  endtask : do_reset

  // Idle level, then active cycles after a forced relink
  task automatic pulse_test(input logic [7:0] v, input int n);
    wr(A_RST_OUT, v);
    @(negedge clk);
    chk("idle", {15'h0, pin}, {15'h0, ~v[0]});
    wr(A_LNK_MODE, 8'h10);
    chk("rcfg", {15'h0, rc}, 16'h0001);
    cnt = 0;
    repeat (40) begin
      @(negedge clk);
      if (pin === v[0]) cnt++;
    end
    chk("pulse", 16'(cnt), 16'(n));
  endtask : pulse_test

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // Sequence
  initial begin
    {clk, srst, role, ssel, link_up, fmode} = 6'h10;
    {csn, sda} = 2'h3;
    dly = 8'h0A;
    req = '0;
    do_reset(1'h1, 1'h1);
    chk("api", {15'h0, api}, 16'h0001);
    rd(A_RST_OUT, 8'h00);
    rd(A_TEST_CODE, 8'h00);
    pulse_test(8'h00, 0);
    pulse_test(8'h02, 0);
    pulse_test(8'h0E, 0);
    pulse_test(8'h08, PC);
    pulse_test(8'hF9, PC);
    wr(A_TX_MODE, 8'h40);
    chk("pd", {15'h0, pd}, 16'h0001);
    csn = 1'h0;
    repeat (4) @(negedge clk);
    chk("pd", {15'h0, pd}, 16'h0001);
    sda = 1'h0;
    repeat (4) @(negedge clk);
    chk("pd", {15'h0, pd}, 16'h0000);
    {csn, sda} = 2'h3;
    rd(A_RST_OUT, 8'h09);
    rd(A_TX_MODE, 8'h40);
    wr(A_LNK_UPD, LNK_START);
    chk("xs", {15'h0, xs}, 16'h0001);
    rd(A_LNK_UPD, 8'h01);
    repeat (15) @(negedge clk);
    rd(A_LNK_UPD, 8'h00);
    fmode = 1'h1;
    wr(A_LNK_UPD, LNK_START);
    repeat (15) @(negedge clk);
    rd(A_LNK_UPD, 8'h02);
    link_up = 1'h1;
    @(negedge clk);
    link_up = 1'h0;
    @(negedge clk);
    chk("api", {15'h0, api}, 16'h0000);
    wr(A_TX_PWR, 8'h00);
    @(negedge clk);
    chk("pwr", {14'h0, pwr}, 16'h0000);
    wr(A_TEST_CODE, TEST_SINGLE);
    wr(A_TEST_CH, 8'h85);
    wr(A_LNK_MODE, 8'h10);
    @(negedge clk);
    chk("tm", {15'h0, tm}, 16'h0001);
    chk("cfg", {6'h0, tcfg}, {6'h0, TK_SINGLE, 1'h1, 7'h05});
    chk("pwr", {14'h0, pwr}, {14'h0, PWR_0DBM});
    wr(A_TEST_CODE, TEST_SWEEP);
    wr(A_LNK_MODE, 8'h10);
    @(negedge clk);
    chk("cfg", {6'h0, tcfg}, {6'h0, TK_SINGLE, 1'h1, 7'h05});
    do_reset(1'h0, 1'h0);
    chk("tm", {15'h0, tm}, 16'h0000);
    pulse_test(8'h08, 0);
    wr(A_LNK_UPD, LNK_START);
    rd(A_LNK_UPD, 8'h00);
    wr(A_RX_MODE, 8'h80);
    chk("pd", {15'h0, pd}, 16'h0001);
    sda = 1'h0;
    repeat (4) @(negedge clk);
    chk("pd", {15'h0, pd}, 16'h0001);
    csn = 1'h0;
    repeat (4) @(negedge clk);
    chk("pd", {15'h0, pd}, 16'h0000);
    {csn, sda} = 2'h3;
    wr(A_TEST_CH, 8'h00);
    wr(A_TEST_CODE, TEST_SWEEP);
    wr(A_LNK_MODE, 8'h10);
    @(negedge clk);
    chk("cfg", {6'h0, tcfg}, {6'h0, TK_SWEEP, 1'h0, 7'h00});
    summarize();
  end

  // Run takes about 385 cycles
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule : tb_device_control_and_relink
`default_nettype wire
